/* File: hdl/tvic_pkg.sv */
// constants shared by the two-level vectored interrupt controller
// assumes an 8-bit special-register port driven by the core on clk_sys_i
package tvic_pkg;

  localparam int unsigned NUM_SRC = 11;

  // special-register addresses
  localparam logic [7:0] ADDR_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_EXTRA_ENABLE = 8'ha7;
  localparam logic [7:0] ADDR_PRIORITY = 8'hb8;
  localparam logic [7:0] ADDR_EXTRA_PRIORITY = 8'hb7;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;

  // values after reset
  localparam logic [7:0] RESET_REG = 8'h00;
  localparam logic [10:0] RESET_SRC = 11'h000;
  localparam logic [15:0] RESET_VEC = 16'h0000;

  // writable bits; the rest read as zero
  localparam logic [7:0] ENABLE_MASK = 8'hff;
  localparam logic [7:0] EXTRA_MASK = 8'hf2;
  localparam logic [7:0] PRIORITY_MASK = 8'h3f;

  localparam int unsigned GLOBAL_EN_BIT = 7;

  // timer control field positions
  localparam int unsigned EXT0_SEL_BIT = 0;
  localparam int unsigned EXT0_PEND_BIT = 1;
  localparam int unsigned EXT1_SEL_BIT = 2;
  localparam int unsigned EXT1_PEND_BIT = 3;
  localparam int unsigned TMR0_OVF_BIT = 5;
  localparam int unsigned TMR1_OVF_BIT = 7;

  // source index is also polling order, 0 first
  localparam int unsigned SRC_EXT0 = 0;
  localparam int unsigned SRC_TMR0 = 1;
  localparam int unsigned SRC_EXT1 = 2;
  localparam int unsigned SRC_TMR1 = 3;
  localparam int unsigned SRC_I2C = 7;
  localparam int unsigned SRC_CONV = 8;

  // enable/priority bit of each source, and which register pair holds it
  localparam logic [2:0] SRC_POS [0:10] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h7, 3'h5, 3'h4};
  localparam logic [10:0] SRC_IN_EXTRA = 11'h7c0;

  localparam logic [15:0] SRC_VEC [0:10] = '{
    16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0053, 16'h0000, 16'h0000, 16'h005b, 16'h004b};

  // nesting state, gray coded along none -> low -> both -> high
  typedef enum logic [1:0] {
    NEST_NONE = 2'h0,
    NEST_LOW = 2'h1,
    NEST_BOTH = 2'h3,
    NEST_HIGH = 2'h2
  } tvic_nest_t;

endpackage

/* File: hdl/tvic_pin_sync.sv */
// two-flop synchroniser with falling-edge detect for the external pins
// assumes pins are asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module tvic_pin_sync #(
  parameter int unsigned WIDTH = 2
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // pins and results
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;
  logic [WIDTH-1:0] prev;

  // idle level of the pins is high, so reset to ones to avoid a false edge
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      meta <= '1;
      stable <= '1;
      prev <= '1;
    end else begin
      meta <= pin_i;
      stable <= meta;
      prev <= stable;
    end
  end

  for (genvar g = 0; g < WIDTH; g++) begin : g_pin
    assign level_o[g] = stable[g];
    assign fall_o[g] = prev[g] & ~stable[g];
  end

endmodule
`default_nettype wire

/* File: hdl/tvic_irq_ctrl.sv */
// two-level vectored interrupt controller for a small 8-bit core
// assumes the core pulses mcycle_start_i once per machine cycle and
// performs the long call whenever vec_req_o is high
//
// Contract
// - eleven sources, each high or low level by its priority bit
// - a high request pre-empts a running low routine, which resumes
// - hold a request while an equal or higher routine runs
// - same-level winner in fixed order, external 0 first, serial 1 last
// - per-source enable; global enable clear blocks all sources
// - sample flags at each machine cycle start, poll them next start
// - vectors: external 0 0003h, timer 0 000bh, external 1 0013h
// - vectors: timer 1 001bh, serial 0 0023h, timer 2 002bh
// - vectors: spi 0053h, serial 1 004bh, counter array 005bh
// - no call off last cycle, on enable/priority write, return, block
// - a denied request is forgotten; each poll uses a fresh sample
// - the call pushes the program counter only, not the status word
// - interrupt return ends current level; plain return leaves it
// - external input edge or level by select; edge flag clears on entry
// - level-mode external flag never cleared by the call
// - timer 0/1 overflow flags, not timer 0 in mode 3; auto-cleared
// - timer 2 request is overflow or capture, neither auto-cleared
// - serial request is received or transmitted flag, not auto-cleared
// - spi request is the or of its four status flags
// - i2c flag set on address match, general call, stop or byte done
// - converter done flag requests service and is not auto-cleared
// - counter array request is the or of six match and two overflow
`timescale 1ns/1ps
`default_nettype none
module tvic_irq_ctrl #(
  // vectors for these two sources are not fixed by the core
  parameter logic [15:0] I2C_VECTOR = 16'h0043,
  parameter logic [15:0] CONV_VECTOR = 16'h003b
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // special-register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  // core sequencing
  input wire logic mcycle_start_i,
  input wire logic last_cycle_i,
  input wire logic irq_reg_write_i,
  input wire logic irq_return_instr_i,
  // external pins
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  // timer events and flags
  input wire logic tmr0_overflow_i,
  input wire logic tmr0_mode3_i,
  input wire logic tmr1_overflow_i,
  input wire logic tmr2_overflow_flag_i,
  input wire logic tmr2_capture_flag_i,
  // serial ports
  input wire logic ser0_rx_byte_flag_i,
  input wire logic ser0_tx_byte_flag_i,
  input wire logic ser1_rx_byte_flag_i,
  input wire logic ser1_tx_byte_flag_i,
  // other peripheral flags
  input wire logic [3:0] spi_flags_i,
  input wire logic i2c_irq_flag_i,
  input wire logic conv_done_flag_i,
  input wire logic [5:0] module_match_flags_i,
  input wire logic [1:0] counter_overflow_flags_i,
  // long call request to the core
  output logic vec_req_o,
  output logic [15:0] vec_addr_o,
  output logic vec_high_o,
  output logic [10:0] irq_ack_o,
  // in-progress state
  output logic active_high_o,
  output logic active_low_o
);

  ////////////////////////////////////////////////////////////////////////
  // special registers

  logic [7:0] interrupt_enable;
  logic [7:0] extra_irq_enable_reg;
  logic [7:0] irq_priority_reg;
  logic [7:0] extra_irq_priority_reg;
  logic ext0_edge_select;
  logic ext1_edge_select;
  logic ext0_pending;
  logic ext1_pending;
  logic tmr0_overflow_flag;
  logic tmr1_overflow_flag;

  logic wr_enable;
  logic wr_extra_enable;
  logic wr_priority;
  logic wr_extra_priority;
  logic wr_timer_ctrl;

  assign wr_enable = sfr_wr_i && (sfr_addr_i == tvic_pkg::ADDR_ENABLE);
  assign wr_extra_enable = sfr_wr_i && (sfr_addr_i == tvic_pkg::ADDR_EXTRA_ENABLE);
  assign wr_priority = sfr_wr_i && (sfr_addr_i == tvic_pkg::ADDR_PRIORITY);
  assign wr_extra_priority = sfr_wr_i && (sfr_addr_i == tvic_pkg::ADDR_EXTRA_PRIORITY);
  assign wr_timer_ctrl = sfr_wr_i && (sfr_addr_i == tvic_pkg::ADDR_TIMER_CTRL);

  // bit 6 of the enable register is kept as plain storage for the debugger
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      interrupt_enable <= tvic_pkg::RESET_REG;
      extra_irq_enable_reg <= tvic_pkg::RESET_REG;
    end else begin
      if (wr_enable) begin
        interrupt_enable <= sfr_wdata_i & tvic_pkg::ENABLE_MASK;
      end
      if (wr_extra_enable) begin
        extra_irq_enable_reg <= sfr_wdata_i & tvic_pkg::EXTRA_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      irq_priority_reg <= tvic_pkg::RESET_REG;
      extra_irq_priority_reg <= tvic_pkg::RESET_REG;
    end else begin
      if (wr_priority) begin
        irq_priority_reg <= sfr_wdata_i & tvic_pkg::PRIORITY_MASK;
      end
      if (wr_extra_priority) begin
        extra_irq_priority_reg <= sfr_wdata_i & tvic_pkg::EXTRA_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sfr_rdata_o <= tvic_pkg::RESET_REG;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        tvic_pkg::ADDR_ENABLE: sfr_rdata_o <= interrupt_enable;
        tvic_pkg::ADDR_EXTRA_ENABLE: sfr_rdata_o <= extra_irq_enable_reg;
        tvic_pkg::ADDR_PRIORITY: sfr_rdata_o <= irq_priority_reg;
        tvic_pkg::ADDR_EXTRA_PRIORITY: sfr_rdata_o <= extra_irq_priority_reg;
        // timer run bits live in the timer block and read as zero here
        tvic_pkg::ADDR_TIMER_CTRL: sfr_rdata_o <= {tmr1_overflow_flag, 1'b0,
          tmr0_overflow_flag, 1'b0, ext1_pending, ext1_edge_select,
          ext0_pending, ext0_edge_select};
        default: sfr_rdata_o <= tvic_pkg::RESET_REG;
      endcase
    end else begin
      sfr_rdata_o <= tvic_pkg::RESET_REG;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-source enable and level

  logic [10:0] en_vec;
  logic [10:0] pri_vec;

  for (genvar g = 0; g < tvic_pkg::NUM_SRC; g++) begin : g_src
    assign en_vec[g] = tvic_pkg::SRC_IN_EXTRA[g]
      ? extra_irq_enable_reg[tvic_pkg::SRC_POS[g]]
      : interrupt_enable[tvic_pkg::SRC_POS[g]];
    assign pri_vec[g] = tvic_pkg::SRC_IN_EXTRA[g]
      ? extra_irq_priority_reg[tvic_pkg::SRC_POS[g]]
      : irq_priority_reg[tvic_pkg::SRC_POS[g]];
  end

  ////////////////////////////////////////////////////////////////////////
  // poll and grant

  tvic_pkg::tvic_nest_t nest;
  tvic_pkg::tvic_nest_t next_nest;
  logic [10:0] src_flag;
  logic [10:0] sample_q;
  logic [10:0] req;
  logic [10:0] req_hi;
  logic [10:0] req_lo;
  logic [10:0] cand;
  logic [10:0] win;
  logic [10:0] win_set_q;
  logic can_hi;
  logic can_lo;
  logic poll_ok;
  logic leave_isr;
  logic grant;
  logic grant_hi;

  assign src_flag[0] = ext0_pending;
  assign src_flag[1] = tmr0_overflow_flag;
  assign src_flag[2] = ext1_pending;
  assign src_flag[3] = tmr1_overflow_flag;
  assign src_flag[4] = ser0_rx_byte_flag_i | ser0_tx_byte_flag_i;
  assign src_flag[5] = tmr2_overflow_flag_i | tmr2_capture_flag_i;
  assign src_flag[6] = |spi_flags_i;
  assign src_flag[7] = i2c_irq_flag_i;
  assign src_flag[8] = conv_done_flag_i;
  assign src_flag[9] = |{counter_overflow_flags_i, module_match_flags_i};
  assign src_flag[10] = ser1_rx_byte_flag_i | ser1_tx_byte_flag_i;

  // sampled once per machine cycle and overwritten each time, so a
  // request refused at one poll is not carried to the next
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sample_q <= tvic_pkg::RESET_SRC;
    end else if (mcycle_start_i) begin
      sample_q <= src_flag;
    end
  end

  assign req = sample_q & en_vec & {11{interrupt_enable[tvic_pkg::GLOBAL_EN_BIT]}};
  assign req_hi = req & pri_vec;
  assign req_lo = req & ~pri_vec;

  assign can_hi = (nest != tvic_pkg::NEST_HIGH) && (nest != tvic_pkg::NEST_BOTH);
  assign can_lo = (nest == tvic_pkg::NEST_NONE);

  always_comb begin
    if (can_hi && (|req_hi)) begin
      cand = req_hi;
    end else if (can_lo) begin
      cand = req_lo;
    end else begin
      cand = tvic_pkg::RESET_SRC;
    end
  end

  // lowest index wins within the chosen level
  assign win = cand & (~cand + 11'h001);

  assign poll_ok = mcycle_start_i && last_cycle_i
    && !irq_reg_write_i && !irq_return_instr_i;
  assign leave_isr = mcycle_start_i && last_cycle_i && irq_return_instr_i;
  assign grant = poll_ok && (|cand);
  assign grant_hi = can_hi && (|req_hi);

  function automatic logic [15:0] vector_of(input logic [10:0] onehot);
    logic [15:0] v;
    v = tvic_pkg::RESET_VEC;
    for (int i = 0; i < tvic_pkg::NUM_SRC; i++) begin
      if (onehot[i]) begin
        if (i == tvic_pkg::SRC_I2C) begin
          v = v | I2C_VECTOR;
        end else if (i == tvic_pkg::SRC_CONV) begin
          v = v | CONV_VECTOR;
        end else begin
          v = v | tvic_pkg::SRC_VEC[i];
        end
      end
    end
    return v;
  endfunction

  // the core pushes only the program counter on this request
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      vec_req_o <= 1'b0;
      vec_addr_o <= tvic_pkg::RESET_VEC;
      vec_high_o <= 1'b0;
      irq_ack_o <= tvic_pkg::RESET_SRC;
      win_set_q <= tvic_pkg::RESET_SRC;
    end else begin
      vec_req_o <= grant;
      irq_ack_o <= grant ? win : tvic_pkg::RESET_SRC;
      if (grant) begin
        vec_addr_o <= vector_of(win);
        vec_high_o <= grant_hi;
        win_set_q <= cand;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // nesting state; plain subroutine returns never reach here

  always_comb begin
    next_nest = nest;
    unique case (nest)
      tvic_pkg::NEST_NONE: begin
        if (grant) begin
          next_nest = grant_hi ? tvic_pkg::NEST_HIGH : tvic_pkg::NEST_LOW;
        end
      end
      tvic_pkg::NEST_LOW: begin
        if (grant) begin
          next_nest = tvic_pkg::NEST_BOTH;
        end else if (leave_isr) begin
          next_nest = tvic_pkg::NEST_NONE;
        end
      end
      tvic_pkg::NEST_BOTH: begin
        if (leave_isr) begin
          next_nest = tvic_pkg::NEST_LOW;
        end
      end
      tvic_pkg::NEST_HIGH: begin
        if (leave_isr) begin
          next_nest = tvic_pkg::NEST_NONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      nest <= tvic_pkg::NEST_NONE;
      active_high_o <= 1'b0;
      active_low_o <= 1'b0;
    end else begin
      nest <= next_nest;
      active_high_o <= (next_nest == tvic_pkg::NEST_HIGH) || (next_nest == tvic_pkg::NEST_BOTH);
      active_low_o <= (next_nest == tvic_pkg::NEST_LOW) || (next_nest == tvic_pkg::NEST_BOTH);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // flags owned here: external pending and timer 0/1 overflow

  logic [1:0] pin_lvl;
  logic [1:0] pin_fall;
  logic ext0_set;
  logic ext1_set;
  logic tmr0_set;

  tvic_pin_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .pin_i({ext_irq_pin_b_i, ext_irq_pin_a_i}),
    .level_o(pin_lvl),
    .fall_o(pin_fall)
  );

  // hardware set beats a clear in the same cycle, whoever clears
  function automatic logic next_flag(input logic set, input logic wr,
                                     input logic wbit, input logic cur,
                                     input logic clr);
    return set | (wr ? wbit : (cur & ~clr));
  endfunction

  assign ext0_set = ext0_edge_select ? pin_fall[0] : ~pin_lvl[0];
  assign ext1_set = ext1_edge_select ? pin_fall[1] : ~pin_lvl[1];
  assign tmr0_set = tmr0_overflow_i & ~tmr0_mode3_i;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ext0_edge_select <= 1'b0;
      ext1_edge_select <= 1'b0;
    end else if (wr_timer_ctrl) begin
      ext0_edge_select <= sfr_wdata_i[tvic_pkg::EXT0_SEL_BIT];
      ext1_edge_select <= sfr_wdata_i[tvic_pkg::EXT1_SEL_BIT];
    end
  end

  // in level mode a still-low pin sets the flag again after each clear
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ext0_pending <= 1'b0;
      ext1_pending <= 1'b0;
    end else begin
      ext0_pending <= next_flag(ext0_set, wr_timer_ctrl,
        sfr_wdata_i[tvic_pkg::EXT0_PEND_BIT], ext0_pending,
        grant && win[tvic_pkg::SRC_EXT0] && ext0_edge_select);
      ext1_pending <= next_flag(ext1_set, wr_timer_ctrl,
        sfr_wdata_i[tvic_pkg::EXT1_PEND_BIT], ext1_pending,
        grant && win[tvic_pkg::SRC_EXT1] && ext1_edge_select);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      tmr0_overflow_flag <= 1'b0;
      tmr1_overflow_flag <= 1'b0;
    end else begin
      tmr0_overflow_flag <= next_flag(tmr0_set, wr_timer_ctrl,
        sfr_wdata_i[tvic_pkg::TMR0_OVF_BIT], tmr0_overflow_flag,
        grant && win[tvic_pkg::SRC_TMR0]);
      tmr1_overflow_flag <= next_flag(tmr1_overflow_i, wr_timer_ctrl,
        sfr_wdata_i[tvic_pkg::TMR1_OVF_BIT], tmr1_overflow_flag,
        grant && win[tvic_pkg::SRC_TMR1]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  a_call_on_poll: assert property (
    vec_req_o |-> $past(mcycle_start_i && last_cycle_i && !irq_reg_write_i && !irq_return_instr_i))
    else $error("long call outside an allowed poll");

  a_hold_equal: assert property (
    (vec_req_o && !vec_high_o) |-> $past(nest == tvic_pkg::NEST_NONE))
    else $error("low call while a routine runs");

  a_preempt_low: assert property (
    (vec_req_o && vec_high_o && $past(active_low_o)) |-> (active_low_o && active_high_o))
    else $error("pre-emption lost the low routine");

  a_global_gate: assert property (
    vec_req_o |-> $past(interrupt_enable[tvic_pkg::GLOBAL_EN_BIT]) && ((irq_ack_o & $past(en_vec)) != 11'h000))
    else $error("call with source or global enable clear");

  a_fixed_order: assert property (
    vec_req_o |-> $onehot(irq_ack_o) && (((irq_ack_o - 11'h001) & win_set_q) == 11'h000))
    else $error("poll order not kept");

  a_vec_ext0: assert property (
    (vec_req_o && irq_ack_o == 11'h001) |-> vec_addr_o == 16'h0003)
    else $error("external 0 vector wrong");

  a_vec_tmr2: assert property (
    (vec_req_o && irq_ack_o == 11'h020) |-> vec_addr_o == 16'h002b)
    else $error("timer 2 vector wrong");

  a_vec_ser1: assert property (
    (vec_req_o && irq_ack_o == 11'h400) |-> vec_addr_o == 16'h004b)
    else $error("serial 1 vector wrong");

  a_return_level: assert property (
    (leave_isr && nest == tvic_pkg::NEST_BOTH) |=> ##1 (!active_high_o && active_low_o))
    else $error("return did not end only the high level");

  a_tmr0_clear: assert property (
    (vec_req_o && irq_ack_o[tvic_pkg::SRC_TMR0] && !$past(tmr0_set)) |-> !tmr0_overflow_flag)
    else $error("timer 0 flag not cleared on entry");

  a_level_kept: assert property (
    (vec_req_o && irq_ack_o[tvic_pkg::SRC_EXT0] && !$past(ext0_edge_select) && !$past(wr_timer_ctrl))
    |-> ext0_pending)
    else $error("level-mode flag cleared by the call");

  c_preempt: cover property (vec_req_o && vec_high_o && active_low_o);
  c_low_call: cover property (vec_req_o && !vec_high_o);
  c_return_both: cover property (leave_isr && nest == tvic_pkg::NEST_BOTH);

endmodule
`default_nettype wire

/* File: sim/tvic_core_model.sv */
// core-side model: paces machine cycles, stacks the program counter on a call
// assumes vec_req_i is a one-cycle pulse and ret_i is held over one machine cycle
`timescale 1ns/1ps
`default_nettype none
module tvic_core_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // controller side
  input wire logic vec_req_i,
  input wire logic [15:0] vec_addr_i,
  input wire logic ret_i,
  output logic mcycle_start_o,
  output logic [3:0] depth_o
);
  logic [1:0] ph;
  logic [15:0] pc;
  logic [7:0] stk [0:15];
  // four clocks to a machine cycle, as in the core
  assign mcycle_start_o = (ph == 2'h3);
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ph <= 2'h0;
      pc <= 16'h0100;
      depth_o <= 4'h0;
    end else begin
      ph <= ph + 2'h1;
      // only the counter goes on the stack, never the status word
      if (vec_req_i) begin
        stk[depth_o] <= pc[7:0];
        stk[depth_o + 4'h1] <= pc[15:8];
        depth_o <= depth_o + 4'h2;
        pc <= vec_addr_i;
      end else if (ret_i && mcycle_start_o && depth_o != 4'h0) begin
        pc <= {stk[depth_o - 4'h1], stk[depth_o - 4'h2]};
        depth_o <= depth_o - 4'h2;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sim/two_level_vectored_irq_ctrl_tb_top.sv */
// testbench: registers, vectoring, polling order, nesting and blocking
// assumes the core model paces machine cycles every four clocks
`timescale 1ns/1ps
`default_nettype none
module two_level_vectored_irq_ctrl_tb_top;
  logic clk_sys_i, reset_i, wr, rd, lc, rw, ret, pa, pb, t0, t0m, t1, vreq, vhi, ah, al, mst;
  logic [7:0] ad, wd, rdata;
  logic [19:0] f;
  logic [15:0] vaddr;
  logic [10:0] ack;
  logic [3:0] depth;
  int err_count;
  int tests_run;
  localparam logic [15:0] VT [0:10] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b,
    16'h0053, 16'h0043, 16'h003b, 16'h005b, 16'h004b};
  tvic_irq_ctrl #(.I2C_VECTOR(16'h0043), .CONV_VECTOR(16'h003b)) u_dut (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .sfr_addr_i(ad), .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_rd_i(rd),
    .sfr_rdata_o(rdata), .mcycle_start_i(mst), .last_cycle_i(lc), .irq_reg_write_i(rw),
    .irq_return_instr_i(ret), .ext_irq_pin_a_i(pa), .ext_irq_pin_b_i(pb), .tmr0_overflow_i(t0),
    .tmr0_mode3_i(t0m), .tmr1_overflow_i(t1), .tmr2_overflow_flag_i(f[4]), .tmr2_capture_flag_i(f[5]),
    .ser0_rx_byte_flag_i(f[0]), .ser0_tx_byte_flag_i(f[1]), .ser1_rx_byte_flag_i(f[2]),
    .ser1_tx_byte_flag_i(f[3]), .spi_flags_i(f[9:6]), .i2c_irq_flag_i(f[10]), .conv_done_flag_i(f[11]),
    .module_match_flags_i(f[17:12]), .counter_overflow_flags_i(f[19:18]), .vec_req_o(vreq),
    .vec_addr_o(vaddr), .vec_high_o(vhi), .irq_ack_o(ack), .active_high_o(ah), .active_low_o(al));
  tvic_core_model u_core (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .vec_req_i(vreq),
    .vec_addr_i(vaddr), .ret_i(ret), .mcycle_start_o(mst), .depth_o(depth));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(posedge clk_sys_i);
    chk({8'h0, rdata}, {8'h0, exp});
  endtask
  // the call pulse lasts one cycle, so every edge is looked at
  task automatic grant(input int s, input logic h);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (vreq !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk({5'h0, ack}, 16'h1 << s);
    chk(vaddr, VT[s]);
    chk({15'h0, vhi}, {15'h0, h});
  endtask
  task automatic none(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      chk({15'h0, vreq}, 16'h0);
    end
  endtask
  task automatic irq_return_instr;
    @(posedge clk_sys_i);
    ret <= 1'b1;
    cyc(4);
    ret <= 1'b0;
  endtask
  function automatic int src_of(input int b);
    if (b < 2) return 4;
    if (b < 4) return 10;
    if (b < 6) return 5;
    if (b < 10) return 6;
    if (b < 12) return b - 3;
    return 9;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] ra [5] = '{8'ha8, 8'ha7, 8'hb8, 8'hb7, 8'h90};
    logic [7:0] rm [5] = '{8'hff, 8'hf2, 8'h3f, 8'hf2, 8'h00};
    for (int i = 0; i < 5; i++) begin
      rreg(ra[i], 8'h00);
      wreg(ra[i], 8'hff);
      rreg(ra[i], rm[i]);
      wreg(ra[i], 8'h00);
    end
  endtask
  task automatic t_vec;
    for (int b = 0; b < 20; b++) begin
      f[b] <= 1'b1;
      grant(src_of(b), 1'b0);
      cyc(1);
      chk({12'h0, depth}, 16'h2);
      irq_return_instr();
      grant(src_of(b), 1'b0);
      f[b] <= 1'b0;
      irq_return_instr();
      none(12);
      chk({15'h0, al}, 16'h0);
    end
  endtask
  task automatic t_order;
    int ob [7] = '{0, 4, 6, 10, 11, 12, 2};
    f <= 20'h01c55;
    for (int i = 0; i < 7; i++) begin
      grant(i + 4, 1'b0);
      f[ob[i]] <= 1'b0;
      irq_return_instr();
    end
  endtask
  task automatic t_preempt;
    wreg(8'hb8, 8'h10);
    f[2] <= 1'b1;
    grant(10, 1'b0);
    f[0] <= 1'b1;
    grant(4, 1'b1);
    cyc(1);
    chk({12'h0, depth}, 16'h4);
    chk({14'h0, ah, al}, 16'h3);
    f[0] <= 1'b0;
    f[2] <= 1'b0;
    f[4] <= 1'b1;
    none(12);
    irq_return_instr();
    // the return may land on the last edge of irq_return_instr, so let it settle
    cyc(1);
    chk({14'h0, ah, al}, 16'h1);
    none(8);
    irq_return_instr();
    grant(5, 1'b0);
    f[4] <= 1'b0;
    irq_return_instr();
    wreg(8'hb8, 8'h00);
  endtask
  task automatic t_block;
    wreg(8'ha8, 8'h3f);
    f[10] <= 1'b1;
    none(12);
    wreg(8'ha7, 8'h70);
    wreg(8'ha8, 8'hbf);
    none(12);
    lc <= 1'b0;
    wreg(8'ha7, 8'hf2);
    none(12);
    rw <= 1'b1;
    lc <= 1'b1;
    none(12);
    f[10] <= 1'b0;
    cyc(8);
    rw <= 1'b0;
    none(12);
  endtask
  task automatic t_tmr;
    t0 <= 1'b1;
    @(posedge clk_sys_i);
    t0 <= 1'b0;
    none(4);
    grant(1, 1'b0);
    rreg(8'h88, 8'h00);
    irq_return_instr();
    none(12);
    t0m <= 1'b1;
    t0 <= 1'b1;
    @(posedge clk_sys_i);
    t0 <= 1'b0;
    none(12);
    t0m <= 1'b0;
    t1 <= 1'b1;
    @(posedge clk_sys_i);
    t1 <= 1'b0;
    grant(3, 1'b0);
    irq_return_instr();
    none(12);
  endtask
  task automatic t_ext;
    pa <= 1'b0;
    grant(0, 1'b0);
    rreg(8'h88, 8'h02);
    pa <= 1'b1;
    cyc(4);
    wreg(8'h88, 8'h00);
    irq_return_instr();
    none(12);
    wreg(8'h88, 8'h05);
    pa <= 1'b0;
    pb <= 1'b0;
    grant(0, 1'b0);
    rreg(8'h88, 8'h0d);
    irq_return_instr();
    grant(2, 1'b0);
    irq_return_instr();
    rreg(8'h88, 8'h05);
    none(12);
    pa <= 1'b1;
    pb <= 1'b1;
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // the whole run needs under two thousand cycles; this is ample headroom
  initial begin
    repeat (50000) @(posedge clk_sys_i);
    err_count++;
    results();
  end
  initial begin
    {reset_i, wr, rd, rw, ret, t0, t0m, t1, ad, wd, f} = '0;
    {lc, pa, pb} = 3'h7;
    err_count = 0;
    tests_run = 0;
    reset_i = 1'b1;
    cyc(4);
    reset_i <= 1'b0;
    t_regs();
    wreg(8'ha8, 8'hbf);
    wreg(8'ha7, 8'hf2);
    t_vec();
    t_order();
    t_preempt();
    t_block();
    t_tmr();
    t_ext();
    results();
  end
endmodule
`default_nettype wire
